// ### hdl/adcts_pkg.sv
// Operation
// - Writing one to start begins a single conversion, or a whole sequence.
// - Start bit clears itself once the conversion has actually begun.
// - Start written while set is ignored; zero writes to trigger bits do nothing.
// - Writing one to flush empties the pipeline and restarts the core next edge; here flush acts only after the trigger busy bit has cleared.
// - Flush aborts running conversions and discards their partial result.
// - After flush, operation resumes; a pending conversion starts afresh.
// - Flush bit reads one until the pipeline has actually been flushed.
// - Run-while-halted at 0 stops converting under debug halt; 1 keeps running.
// - Run-while-halted survives soft reset; only system reset clears it.
// - Each synchronized register's busy flag sets on write, clears when done.
// - Busy bits: 0 reset,1 enable,2 input,3 ctrl,4 avg,5 samp,6-7 window,8-9,10 trig.
// - Result register holds up to 16 bits; single plain conversion gives 12.
// - Left alignment puts upper eight bits at 15:8, remaining four at 7:4.
// - Right alignment without oversampling puts the 12-bit result at 11:0.
// - Oversampled result spans up to bits 15:0, extent set by averaging.
// - Sequence register has 32 enables; bit n includes input n in sequence.
// - Sequence starts at lowest enabled input, steps to next higher after each.
// - All sequence enables zero disables the sequencer; single input select used.
// - Calibration writes only while disabled, and subject to write protection.
package adcts_pkg;
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_INPUT_SEL = 8'h04;
    localparam logic [7:0] OFS_CTRL_C = 8'h08;
    localparam logic [7:0] OFS_AVG = 8'h0C;
    localparam logic [7:0] OFS_SOFT_TRIG = 8'h18;
    localparam logic [7:0] OFS_DEBUG = 8'h1C;
    localparam logic [7:0] OFS_SYNC_BUSY = 8'h20;
    localparam logic [7:0] OFS_RESULT = 8'h24;
    localparam logic [7:0] OFS_SEQ = 8'h28;
    localparam logic [7:0] OFS_CFG_BASE = 8'h2C;
    localparam logic [7:0] OFS_ANALOG_BIAS_CALIBRATION = 8'h48;
    localparam int CFG_COUNT = 5;
    localparam int TRIG_FLUSH_BIT = 0;
    localparam int TRIG_START_BIT = 1;
    localparam int CTRL_SOFT_RESET_BIT_BIT = 0;
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int CONTROL_THIRD_ALIGN_BIT = 1;
    localparam int DBG_RUN_BIT = 0;
    localparam int AVG_NUM_LSB = 0;
    localparam int AVG_ADJ_LSB = 4;
    localparam int ANALOG_BIAS_CALIBRATION_COMP_LSB = 0;
    localparam int ANALOG_BIAS_CALIBRATION_REFBUF_LSB = 8;
    localparam int BUSY_SOFT_RESET_BIT = 0;
    localparam int BUSY_ENABLE = 1;
    localparam int BUSY_INPUT = 2;
    localparam int BUSY_CONTROL_THIRD = 3;
    localparam int BUSY_AVG = 4;
    localparam int BUSY_CFG_BASE = 5;
    localparam int BUSY_TRIG = 10;
    localparam logic [3:0] AVG_MAX = 4'hA;
    localparam int SYNC_TIME_NS = 40;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_FLUSH} adcts_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } adcts_apb_req_t;

    typedef struct packed {
        logic [1:0] halt_pipe;
        logic [1:0] lock_pipe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic enable;
        logic soft_reset_bit_pend;
        logic align_high;
        logic [3:0] avg_num;
        logic [2:0] avg_adj;
        logic [4:0] in_sel;
        logic [CFG_COUNT-1:0][15:0] cfg;
        logic dbg_run;
        logic [31:0] seq_mask;
        logic [2:0] refbuf;
        logic [2:0] comp;
        logic [10:0] busy;
        logic [3:0] sync_cnt;
        logic trig_start;
        logic trig_flush;
        adcts_state_t state;
        logic resume;
        logic seq_on;
        logic [4:0] channel;
        logic [10:0] sample_cnt;
        logic [21:0] acc;
        logic [15:0] result;
        logic conv_start;
        logic conv_abort;
        logic hold;
        logic res_valid;
    } adcts_regs_t;

    localparam adcts_regs_t REGS_RESET = '0;
endpackage

// ### hdl/adcts_top.sv
`timescale 1ns/1ns
module adcts_top
    import adcts_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int SYNC_CNT = SYNC_CYCLES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // System pins
    input wire logic DEBUG_HALT,
    input wire logic WRITE_LOCK,
    // Converter core
    input wire logic CONV_DONE,
    input wire logic [11:0] CONV_DATA,
    output logic CONV_START,
    output logic CONV_ABORT,
    output logic [4:0] CONV_CHANNEL,
    output logic CORE_ENABLE,
    output logic CORE_HOLD,
    output logic [2:0] BIAS_REFBUF,
    output logic [2:0] BIAS_COMP,
    output logic RESULT_VALID
);
    if (ADDR_W < 8 || SYNC_CNT < 1 || SYNC_CNT > 15) begin : g_bad_param
        $error("adcts_top: ADDR_W must be >= 8 and SYNC_CNT within 1..15");
    end

    adcts_regs_t st_reg;
    adcts_regs_t st_next;
    adcts_apb_req_t req;
    logic [1:0] rst_pipe_reg;
    logic rst_n;
    logic setup;
    logic access;
    logic hit;
    logic prot;
    logic blocked;
    logic [31:0] rdata;
    logic [10:0] set_busy;
    logic sync_done;
    logic trig_vis;
    logic halted;
    logic launch_ok;
    logic flush_go;
    logic [5:0] first_pick;
    logic [5:0] next_pick;
    logic [21:0] sum;
    logic [3:0] avg_eff;
    logic [10:0] last_sample;
    logic [15:0] formatted;

    // Lowest enabled input at or above from; MSB flags a find
    function automatic logic [5:0] seq_pick(input logic [31:0] mask, input logic [5:0] from);
        logic [5:0] r;
        r = '0;
        for (int i = 31; i >= 0; i--) begin
            if (mask[i] && 6'(i) >= from) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_pipe_reg <= 2'b00;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    assign req = '{psel: PSEL, penable: PENABLE, pwrite: PWRITE,
                   paddr: PADDR[7:0], pwdata: PWDATA};
    assign setup = req.psel && !req.penable && !st_reg.pready;
    assign access = req.psel && req.penable && st_reg.pready;
    assign trig_vis = !st_reg.busy[BUSY_TRIG];
    assign halted = st_reg.halt_pipe[1] && !st_reg.dbg_run;
    assign launch_ok = st_reg.trig_start && trig_vis && st_reg.enable && !halted;
    assign flush_go = st_reg.trig_flush && trig_vis && !halted;
    assign first_pick = seq_pick(st_reg.seq_mask, 6'h00);
    assign next_pick = seq_pick(st_reg.seq_mask, 6'({1'b0, st_reg.channel} + 6'h01));
    assign sum = st_reg.acc + 22'(CONV_DATA);
    assign avg_eff = (st_reg.avg_num > AVG_MAX) ? AVG_MAX : st_reg.avg_num;
    assign last_sample = 11'((11'h001 << avg_eff) - 11'h001);

    // Result formatting
    always_comb begin
        if (avg_eff == 4'h0) begin
            formatted = st_reg.align_high ? {sum[11:0], 4'h0} : {4'h0, sum[11:0]};
        end else begin
            formatted = 16'(sum >> st_reg.avg_adj);
        end
    end

    // Address decode and read mux
    always_comb begin
        hit = 1'b1;
        prot = 1'b1;
        rdata = '0;
        case (req.paddr)
            OFS_CTRL_A: rdata = {30'h0, st_reg.enable, 1'b0};
            OFS_INPUT_SEL: rdata = {27'h0, st_reg.in_sel};
            OFS_CTRL_C: rdata = {30'h0, st_reg.align_high, 1'b0};
            OFS_AVG: rdata = {25'h0, st_reg.avg_adj, st_reg.avg_num};
            OFS_SOFT_TRIG: rdata = {30'h0, st_reg.trig_start, st_reg.trig_flush};
            OFS_DEBUG: rdata = {31'h0, st_reg.dbg_run};
            OFS_SYNC_BUSY: begin
                rdata = {21'h0, st_reg.busy};
                prot = 1'b0;
            end
            OFS_RESULT: begin
                rdata = {16'h0, st_reg.result};
                prot = 1'b0;
            end
            OFS_SEQ: rdata = st_reg.seq_mask;
            OFS_ANALOG_BIAS_CALIBRATION: rdata = {21'h0, st_reg.refbuf, 5'h0, st_reg.comp};
            default: begin
                hit = 1'b0;
                for (int i = 0; i < CFG_COUNT; i++) begin
                    if (req.paddr == 8'(OFS_CFG_BASE + 8'(4 * i))) begin
                        hit = 1'b1;
                        rdata = {16'h0, st_reg.cfg[i]};
                    end
                end
            end
        endcase
        if ((PADDR >> 8) != '0) begin
            hit = 1'b0;
        end
        blocked = req.pwrite && ((prot && st_reg.lock_pipe[1])
                  || (req.paddr == OFS_ANALOG_BIAS_CALIBRATION && st_reg.enable));
    end

    always_comb begin
        st_next = st_reg;
        set_busy = '0;
        sync_done = 1'b0;
        st_next.halt_pipe = {st_reg.halt_pipe[0], DEBUG_HALT};
        st_next.lock_pipe = {st_reg.lock_pipe[0], WRITE_LOCK};
        st_next.hold = halted;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.prdata = '0;
        st_next.conv_start = 1'b0;
        st_next.conv_abort = 1'b0;
        st_next.res_valid = 1'b0;

        // APB: one cycle of setup, zero-wait access
        if (setup) begin
            st_next.pready = 1'b1;
            st_next.pslverr = !hit || blocked;
            st_next.prdata = (req.pwrite || !hit) ? 32'h0 : rdata;
        end

        // Conversion sequencer
        case (st_reg.state)
            ST_IDLE: begin
                if (flush_go) begin
                    st_next.conv_abort = 1'b1;
                    st_next.resume = 1'b0;
                    st_next.state = ST_FLUSH;
                end else if (launch_ok) begin
                    st_next.trig_start = 1'b0;
                    st_next.seq_on = |st_reg.seq_mask;
                    st_next.channel = (|st_reg.seq_mask) ? first_pick[4:0] : st_reg.in_sel;
                    st_next.acc = '0;
                    st_next.sample_cnt = '0;
                    st_next.conv_start = 1'b1;
                    st_next.state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (flush_go) begin
                    st_next.conv_abort = 1'b1;
                    st_next.acc = '0;
                    st_next.sample_cnt = '0;
                    st_next.resume = 1'b1;
                    st_next.state = ST_FLUSH;
                end else if (!st_reg.enable) begin
                    st_next.conv_abort = 1'b1;
                    st_next.state = ST_IDLE;
                end else if (CONV_DONE && !halted) begin
                    if (st_reg.sample_cnt == last_sample) begin
                        st_next.result = formatted;
                        st_next.res_valid = 1'b1;
                        st_next.acc = '0;
                        st_next.sample_cnt = '0;
                        if (st_reg.seq_on && next_pick[5]) begin
                            st_next.channel = next_pick[4:0];
                            st_next.conv_start = 1'b1;
                        end else begin
                            st_next.state = ST_IDLE;
                        end
                    end else begin
                        st_next.acc = sum;
                        st_next.sample_cnt = 11'(st_reg.sample_cnt + 11'h001);
                        st_next.conv_start = 1'b1;
                    end
                end
            end
            ST_FLUSH: begin
                st_next.trig_flush = 1'b0;
                st_next.acc = '0;
                st_next.sample_cnt = '0;
                // Resume waits out a debug halt so no sample starts while stopped
                if (!st_reg.resume) begin
                    st_next.state = ST_IDLE;
                end else if (!halted) begin
                    st_next.conv_start = 1'b1;
                    st_next.state = ST_CONVERT;
                end
            end
            default: st_next.state = ST_IDLE;
        endcase

        // Register writes; placed after the sequencer so a flush set beats its clear (a start write while set is ignored)
        if (access && req.pwrite && !st_reg.pslverr) begin
            case (req.paddr)
                OFS_CTRL_A: begin
                    st_next.enable = req.pwdata[CTRL_ENABLE_BIT];
                    if (req.pwdata[CTRL_SOFT_RESET_BIT_BIT]) begin
                        st_next.soft_reset_bit_pend = 1'b1;
                    end
                    set_busy[BUSY_ENABLE] = 1'b1;
                    set_busy[BUSY_SOFT_RESET_BIT] = req.pwdata[CTRL_SOFT_RESET_BIT_BIT];
                end
                OFS_INPUT_SEL: begin
                    st_next.in_sel = req.pwdata[4:0];
                    set_busy[BUSY_INPUT] = 1'b1;
                end
                OFS_CTRL_C: begin
                    st_next.align_high = req.pwdata[CONTROL_THIRD_ALIGN_BIT];
                    set_busy[BUSY_CONTROL_THIRD] = 1'b1;
                end
                OFS_AVG: begin
                    st_next.avg_num = req.pwdata[AVG_NUM_LSB +: 4];
                    st_next.avg_adj = req.pwdata[AVG_ADJ_LSB +: 3];
                    set_busy[BUSY_AVG] = 1'b1;
                end
                OFS_SOFT_TRIG: begin
                    if (req.pwdata[TRIG_START_BIT] && !st_reg.trig_start) begin
                        st_next.trig_start = 1'b1;
                    end
                    if (req.pwdata[TRIG_FLUSH_BIT]) begin
                        st_next.trig_flush = 1'b1;
                    end
                    set_busy[BUSY_TRIG] = 1'b1;
                end
                OFS_DEBUG: st_next.dbg_run = req.pwdata[DBG_RUN_BIT];
                OFS_SEQ: st_next.seq_mask = req.pwdata;
                OFS_ANALOG_BIAS_CALIBRATION: begin
                    st_next.refbuf = req.pwdata[ANALOG_BIAS_CALIBRATION_REFBUF_LSB +: 3];
                    st_next.comp = req.pwdata[ANALOG_BIAS_CALIBRATION_COMP_LSB +: 3];
                end
                default: begin
                    for (int i = 0; i < CFG_COUNT; i++) begin
                        if (req.paddr == 8'(OFS_CFG_BASE + 8'(4 * i))) begin
                            st_next.cfg[i] = req.pwdata[15:0];
                            set_busy[BUSY_CFG_BASE + i] = 1'b1;
                        end
                    end
                end
            endcase
        end

        // Shared synchronization timer; a new write restarts it
        if (set_busy != '0) begin
            st_next.busy = st_next.busy | set_busy;
            st_next.sync_cnt = 4'(SYNC_CNT);
        end else if (st_reg.sync_cnt != 4'h0) begin
            st_next.sync_cnt = 4'(st_reg.sync_cnt - 4'h1);
            if (st_reg.sync_cnt == 4'h1) begin
                st_next.busy = '0;
                sync_done = 1'b1;
            end
        end

        // Soft reset clears everything but the debug bit, the halt/lock synchronizers, bus answer and an abort of a running conversion
        if (sync_done && st_reg.soft_reset_bit_pend) begin
            st_next = REGS_RESET;
            st_next.dbg_run = st_reg.dbg_run;
            st_next.halt_pipe = {st_reg.halt_pipe[0], DEBUG_HALT};
            st_next.lock_pipe = {st_reg.lock_pipe[0], WRITE_LOCK};
            st_next.pready = setup;
            st_next.pslverr = setup && (!hit || blocked);
            st_next.prdata = (setup && !req.pwrite && hit) ? rdata : 32'h0;
            st_next.conv_abort = (st_reg.state != ST_IDLE);
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= REGS_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PRDATA = st_reg.prdata;
    assign PREADY = st_reg.pready;
    assign PSLVERR = st_reg.pslverr;
    assign CONV_START = st_reg.conv_start;
    assign CONV_ABORT = st_reg.conv_abort;
    assign CONV_CHANNEL = st_reg.channel;
    assign CORE_ENABLE = st_reg.enable;
    assign CORE_HOLD = st_reg.hold;
    assign BIAS_REFBUF = st_reg.refbuf;
    assign BIAS_COMP = st_reg.comp;
    assign RESULT_VALID = st_reg.res_valid;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    logic trig_wr;
    logic soft_reset_bit_do;
    assign trig_wr = access && req.pwrite && !st_reg.pslverr && req.paddr == OFS_SOFT_TRIG;
    assign soft_reset_bit_do = sync_done && st_reg.soft_reset_bit_pend;

    start_clears_a: assert property (st_reg.conv_start && $past(st_reg.state == ST_IDLE)
        |-> !st_reg.trig_start) else $error("start bit not cleared at launch");
    zero_write_a: assert property (trig_wr && !req.pwdata[TRIG_START_BIT] && !st_reg.trig_start
        && !soft_reset_bit_do |=> !st_reg.trig_start) else $error("zero write set start");
    flush_abort_a: assert property (flush_go && st_reg.state != ST_FLUSH && !soft_reset_bit_do
        |=> st_reg.conv_abort ##1 (st_reg.state != ST_FLUSH || $past(halted)))
        else $error("flush not acted");
    flush_discard_a: assert property (flush_go && st_reg.state == ST_CONVERT && !soft_reset_bit_do
        |=> !st_reg.res_valid && st_reg.acc == 22'h0) else $error("flush kept result");
    flush_resume_a: assert property (st_reg.state == ST_FLUSH && st_reg.resume && !soft_reset_bit_do && !halted
        |=> st_reg.conv_start && st_reg.state == ST_CONVERT) else $error("no resume");
    flush_flag_a: assert property ($fell(st_reg.trig_flush) && !$past(soft_reset_bit_do)
        |-> $past(st_reg.state == ST_FLUSH)) else $error("flush bit fell early");
    halt_stop_a: assert property ($past(halted) |-> !st_reg.conv_start)
        else $error("conversion started while halted");
    dbg_keep_a: assert property (soft_reset_bit_do |=> st_reg.dbg_run == $past(st_reg.dbg_run))
        else $error("debug bit lost at soft reset");
    busy_set_a: assert property (set_busy != '0 |=> st_reg.busy != '0
        && st_reg.sync_cnt == 4'(SYNC_CNT)) else $error("busy flag not set");
    busy_clear_a: assert property (st_reg.sync_cnt == 4'h1 && set_busy == '0
        |=> st_reg.busy == '0) else $error("busy flag not cleared");
    align_fmt_a: assert property (st_reg.res_valid && st_reg.avg_num == 4'h0 |->
        (st_reg.align_high ? st_reg.result[3:0] == 4'h0 : st_reg.result[15:12] == 4'h0))
        else $error("result alignment wrong");
    seq_first_a: assert property (st_reg.conv_start && $past(st_reg.state == ST_IDLE)
        && st_reg.seq_on |-> st_reg.seq_mask[st_reg.channel]
        && (st_reg.seq_mask & ((32'h1 << st_reg.channel) - 32'h1)) == 32'h0)
        else $error("sequence not at lowest input");
    seq_off_a: assert property (st_reg.conv_start && $past(st_reg.state == ST_IDLE)
        && !st_reg.seq_on |-> st_reg.channel == $past(st_reg.in_sel))
        else $error("single input not used");
    analog_bias_calibration_lock_a: assert property (st_reg.enable && !soft_reset_bit_do
        |=> $stable(st_reg.refbuf) && $stable(st_reg.comp))
        else $error("calibration written while enabled");

    seq_two_c: cover property (st_reg.res_valid && st_reg.seq_on ##[1:50] st_reg.res_valid);
    flush_run_c: cover property (st_reg.state == ST_FLUSH && st_reg.resume);
    avg_res_c: cover property (st_reg.res_valid && st_reg.avg_num != 4'h0);
    halt_c: cover property (halted && st_reg.state == ST_CONVERT);
endmodule

// ### bench/adcts_top_test.sv
`timescale 1ns/1ns
module adcts_top_test;
    import adcts_pkg::*;
    logic CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd, mask;
    logic PREADY, PSLVERR, err, DEBUG_HALT = 0, WRITE_LOCK = 0, CONV_DONE = 0;
    logic [11:0] CONV_DATA = 12'h000;
    logic CONV_START, CONV_ABORT, CORE_ENABLE, CORE_HOLD, RESULT_VALID;
    logic [4:0] CONV_CHANNEL;
    logic [2:0] BIAS_REFBUF, BIAS_COMP;
    int n_errors = 0, compares = 0, cnt = 0, dly = 3, n_rv = 0, n_ab = 0, s, k;
    int ch_q[$], dq[$], sum, kd;
    logic [7:0] ra[6] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h48};
    adcts_top i_dut (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .DEBUG_HALT(DEBUG_HALT), .WRITE_LOCK(WRITE_LOCK),
        .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .CONV_START(CONV_START),
        .CONV_ABORT(CONV_ABORT), .CONV_CHANNEL(CONV_CHANNEL), .CORE_ENABLE(CORE_ENABLE),
        .CORE_HOLD(CORE_HOLD), .BIAS_REFBUF(BIAS_REFBUF), .BIAS_COMP(BIAS_COMP),
        .RESULT_VALID(RESULT_VALID));
    always #5 CLK = ~CLK;
    // Core stand-in: answers each start after dly cycles, forgets it on abort
    always @(posedge CLK) begin
        CONV_DONE <= 1'b0;
        CONV_DATA <= 12'(~CONV_DATA);
        n_rv <= n_rv + int'(RESULT_VALID === 1'b1);
        n_ab <= n_ab + int'(CONV_ABORT === 1'b1);
        if (CONV_ABORT === 1'b1) begin
            cnt <= 0;
        end else if (CONV_START === 1'b1) begin
            cnt <= dly;
            ch_q.push_back(int'(CONV_CHANNEL));
        end else if (cnt == 1) begin
            CONV_DONE <= 1'b1;
            kd = int'($urandom % 4096);
            CONV_DATA <= 12'(kd);
            dq.push_back(kd);
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (PREADY !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t no bus answer", $time);
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
        // One idle edge so the next call never re-drives the same strobe at once
        @(posedge CLK);
    endtask
    task automatic wait_rv(input int target);
        int n;
        for (n = 0; n < 3000 && n_rv < target; n++) @(posedge CLK);
        repeat (30) @(posedge CLK);
        chk(32'(n_rv), 32'(target));
    endtask
    task automatic go(input int n);
        int base;
        base = n_rv;
        ch_q.delete();
        dq.delete();
        apb(1, OFS_SOFT_TRIG, 32'h2);
        apb(1, OFS_SOFT_TRIG, 32'h2);
        apb(0, OFS_SYNC_BUSY, 32'h0);
        chk(32'(rd[BUSY_TRIG]), 32'h1);
        wait_rv(base + n);
        apb(0, OFS_SYNC_BUSY, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic finish_test;
        $display("Errors: %0d, compares: %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(43134));
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        repeat (4) @(posedge CLK);
        foreach (ra[i]) begin
            apb(0, ra[i], 32'h0);
            chk(rd, 32'h0);
        end
        apb(0, 8'h44, 32'h0);
        chk(32'(err), 32'h1);
        apb(1, OFS_ANALOG_BIAS_CALIBRATION, 32'h0000_0503);
        apb(0, OFS_ANALOG_BIAS_CALIBRATION, 32'h0);
        chk(rd, 32'h503);
        chk({26'h0, BIAS_REFBUF, BIAS_COMP}, 32'h2B);
        apb(1, 8'h00, 32'h2);
        chk(32'(CORE_ENABLE), 32'h1);
        apb(1, OFS_ANALOG_BIAS_CALIBRATION, 32'h0);
        chk(32'(err), 32'h1);
        WRITE_LOCK <= 1'b1;
        repeat (4) @(posedge CLK);
        apb(1, OFS_SEQ, 32'h1);
        chk(32'(err), 32'h1);
        WRITE_LOCK <= 1'b0;
        repeat (4) @(posedge CLK);
        for (int al = 0; al < 2; al++) begin
            s = int'($urandom % 32);
            apb(1, OFS_INPUT_SEL, 32'(s));
            apb(1, OFS_CTRL_C, 32'(al * 2));
            go(1);
            chk(32'(ch_q[0]), 32'(s));
            apb(0, OFS_RESULT, 32'h0);
            chk(rd, (al == 1) ? 32'(dq[0] << 4) : 32'(dq[0]));
        end
        mask = ($urandom & 32'h8421_1248) | 32'h0000_0100;
        apb(1, OFS_CTRL_C, 32'h0);
        apb(1, OFS_SEQ, mask);
        go($countones(mask));
        k = 0;
        for (int i = 0; i < 32; i++) begin
            if (mask[i] && k < ch_q.size()) begin
                chk(32'(ch_q[k]), 32'(i));
                k++;
            end
        end
        apb(0, OFS_RESULT, 32'h0);
        chk(rd, 32'(dq[dq.size() - 1]));
        apb(1, OFS_SEQ, 32'h0);
        apb(1, OFS_AVG, 32'h0000_0011);
        go(1);
        sum = 0;
        foreach (dq[i]) sum += dq[i];
        chk(32'(dq.size()), 32'h2);
        apb(0, OFS_RESULT, 32'h0);
        chk(rd, 32'((sum >> 1) & 16'hFFFF));
        apb(1, OFS_AVG, 32'h0);
        dly = 60;
        k = n_ab;
        go(0);
        apb(1, OFS_SOFT_TRIG, 32'h1);
        apb(0, OFS_SOFT_TRIG, 32'h0);
        chk(32'(rd[TRIG_FLUSH_BIT]), 32'h1);
        wait_rv(n_rv + 1);
        chk(32'(n_ab - k), 32'h1);
        chk(32'(ch_q.size()), 32'h2);
        chk(32'(ch_q[1]), 32'(ch_q[0]));
        dly = 3;
        DEBUG_HALT <= 1'b1;
        repeat (8) @(posedge CLK);
        chk(32'(CORE_HOLD), 32'h1);
        apb(1, OFS_DEBUG, 32'h1);
        repeat (8) @(posedge CLK);
        chk(32'(CORE_HOLD), 32'h0);
        apb(1, 8'h00, 32'h1);
        repeat (10) @(posedge CLK);
        apb(0, OFS_DEBUG, 32'h0);
        chk(rd, 32'h1);
        chk({26'h0, BIAS_REFBUF, BIAS_COMP}, 32'h0);
        finish_test();
    end
endmodule
